// ### rtl/cfgpin_ctrl.sv
// configuration phase pin control: mode, clock, status and handshake pins
// Summary of operation
// - sample mode pins before load; decode six load modes.
// - drive load clock in master and async peripheral; else it is input.
// - after load, load clock gets weak pull-up, usable as readback clock.
// - release done pin at completion (driven low before); only its pull-up is configurable.
// - external low on done optionally holds both gsr release and user output enable.
// - while reprogram input is low, clear configuration memory.
// - after reprogram rises, one full clear, then release init line, then wait.
// - peripheral modes drive ready/busy; host writes only when ready.
// - async peripheral read while selected shows ready on data bit seven.
// - master parallel gives address strobe rise before each address change.
// - high-during-load pin stays high until done, then user pin.
// - without scan option, scan functions off after done; pins user.
// - scan inputs come straight from pads; also reach logic after done.
// - unused outputs stay high impedance with pull-up during load.
// - mode pins become user pins after done.
// - low-during-load pin stays low until done, then user pin.
// - during load, pull init low on detected data error.
// - selected is cs low low and cs high high; write beats read.
// - serial out changes on falling clock, 1.5 periods after input.
//
// Added by the designer: the plain strobed port and the placing of the registers.
module cfgpin_ctrl
  import cfgpin_pkg::*;
#(
  parameter int CLR_FRAMES = CLEAR_FRAMES,
  parameter int BYTE_BITS  = 8
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_reprogram_n,
  input  wire logic        i_init_n,
  input  wire logic [2:0]  i_mode_sel,
  input  wire logic        i_cfg_load_clock,
  input  wire logic        i_serial_din,
  input  wire logic [7:0]  i_data,
  input  wire logic        i_chip_select_low,
  input  wire logic        i_chip_select_high,
  input  wire logic        i_write_strobe_n,
  input  wire logic        i_read_strobe_n,
  input  wire logic        i_done_pin,
  input  wire logic        i_data_error,
  input  wire logic        i_load_complete,
  input  wire logic        i_byte_taken,
  input  wire logic        i_done_hold_en,
  input  wire logic        i_done_pullup_en,
  input  wire logic        i_scan_option,
  input  wire logic [2:0]  i_scan_pads,
  output logic [2:0]       o_mode_latched,
  output logic             o_mode_valid,
  output cfgpin_pad_t      o_cfg_load_clock,
  output logic             o_cfg_load_clock_pullup,
  output logic             o_readback_clk,
  output cfgpin_pad_t      o_done,
  output logic             o_done_pullup,
  output logic             o_gsr_release,
  output cfgpin_pad_t      o_init,
  output logic             o_mem_clear,
  output cfgpin_pad_t      o_high_during_load,
  output cfgpin_pad_t      o_low_during_load,
  output cfgpin_pad_t      o_ready_busy,
  output cfgpin_pad_t      o_data_bit_seven,
  output cfgpin_pad_t      o_addr_strobe,
  output logic [15:0]      o_prom_addr_low,
  output logic             o_prom_addr_oe_n,
  output logic [7:0]       o_byte_data,
  output logic             o_byte_valid,
  output cfgpin_pad_t      o_serial_dout,
  output logic [2:0]       o_scan_to_logic,
  output logic             o_scan_enabled,
  output logic             o_user_io_enable,
  output logic             o_pullups_on
);

  initial begin
    if (CLR_FRAMES < 1 || BYTE_BITS != 8) $error("bad parameters");
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam int NS = 19;
  logic [NS-1:0] s1_r, s2_r;
  logic [NS-1:0] raw;
  assign raw = {i_reprogram_n, i_init_n, i_mode_sel, i_cfg_load_clock,
                i_serial_din, i_data, i_chip_select_low,
                i_chip_select_high, i_write_strobe_n, i_read_strobe_n};
  always_ff @(posedge i_sys_clk) begin
    s1_r <= raw;
    s2_r <= s1_r;
  end
  logic       prog_n, init_in_n, cfg_load_clock_in, din, cs0, cs1, ws_n, rs_n;
  logic [2:0] mode_in;
  logic [7:0] data_in;
  assign {prog_n, init_in_n, mode_in, cfg_load_clock_in, din, data_in,
          cs0, cs1, ws_n, rs_n} = s2_r;
  logic done_s1_r, done_s2_r;
  always_ff @(posedge i_sys_clk) begin
    done_s1_r <= i_done_pin;
    done_s2_r <= done_s1_r;
  end

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  cfgpin_state_t st_r, st_nxt;
  logic [2:0]  mode_r, mode_nxt;
  logic        mvalid_r, mvalid_nxt;
  logic [15:0] tick_r, tick_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic        is_master, is_par, is_aperi, is_speri, is_drv_clk;
  always_comb begin
    is_par    = (mode_r == MODE_MASTER_PAR_LOW) ||
                (mode_r == MODE_MASTER_PAR_HIGH);
    is_aperi  = (mode_r == MODE_ASYNC_PERIPH);
    is_speri  = (mode_r == MODE_SYNC_PERIPH);
    is_master = is_par || (mode_r == MODE_MASTER_SERIAL);
    is_drv_clk = is_master || is_aperi;
  end

  logic in_load;
  assign in_load = (st_r != CFG_DONE);

  // ----------------------------------------------------------------
  // sequence: clear, wait, load, done
  // ----------------------------------------------------------------
  logic tick;
  logic prog_d_r;
  assign tick = (tick_r == 16'(CLR_TICK_CYC - 1));
  always_comb begin
    st_nxt     = st_r;
    mode_nxt   = mode_r;
    mvalid_nxt = mvalid_r;
    tick_nxt   = tick ? 16'h0000 : tick_r + 16'h0001;
    cnt_nxt    = cnt_r;
    if (!prog_n) begin
      st_nxt     = CFG_CLEAR;
      cnt_nxt    = 16'h0000;
      mvalid_nxt = 1'b0;
    end else begin
      case (st_r)
        CFG_CLEAR: begin
          if (tick) begin
            cnt_nxt = cnt_r + 16'h0001;
            if (cnt_r == 16'(CLR_FRAMES - 1)) begin
              st_nxt  = CFG_WAIT;
              cnt_nxt = 16'h0000;
            end
          end
        end
        CFG_WAIT: begin
          if (!init_in_n) begin
            cnt_nxt = 16'h0000;
          end else if (tick) begin
            cnt_nxt = cnt_r + 16'h0001;
            if (cnt_r == 16'(MODE_WAIT_TK - 1)) begin
              mode_nxt   = mode_in;
              mvalid_nxt = 1'b1;
              st_nxt     = CFG_LOAD;
              cnt_nxt    = 16'h0000;
            end
          end
        end
        CFG_LOAD: begin
          if (i_data_error) begin
            st_nxt = CFG_ERROR;
          end else if (i_load_complete) begin
            st_nxt = CFG_DONE;
          end
        end
        CFG_ERROR: st_nxt = CFG_ERROR;
        default:   st_nxt = st_r;
      endcase
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st_r     <= CFG_CLEAR;
      mode_r   <= 3'h0;
      mvalid_r <= 1'b0;
      tick_r   <= 16'h0000;
      cnt_r    <= 16'h0000;
      prog_d_r <= 1'b1;
    end else begin
      st_r     <= st_nxt;
      mode_r   <= mode_nxt;
      mvalid_r <= mvalid_nxt;
      tick_r   <= tick_nxt;
      cnt_r    <= cnt_nxt;
      prog_d_r <= prog_n;
    end
  end

  // ----------------------------------------------------------------
  // clock generation and edge detection
  // ----------------------------------------------------------------
  logic [7:0] div_r, div_nxt;
  logic       gclk_r, gclk_nxt, cin_d_r;
  logic       run_clk;
  assign run_clk = (st_r == CFG_LOAD) || (st_r == CFG_ERROR);
  always_comb begin
    div_nxt  = div_r;
    gclk_nxt = gclk_r;
    if (run_clk && is_drv_clk) begin
      if (div_r == 8'(CFG_LOAD_CLOCK_HALF_CYC - 1)) begin
        div_nxt  = 8'h00;
        gclk_nxt = ~gclk_r;
      end else begin
        div_nxt = div_r + 8'h01;
      end
    end else begin
      div_nxt  = 8'h00;
      gclk_nxt = 1'b0;
    end
  end
  logic cfg_load_clock_cur, cfg_load_clock_prev, rise, fall;
  assign cfg_load_clock_cur  = is_drv_clk ? gclk_nxt : cfg_load_clock_in;
  assign cfg_load_clock_prev = is_drv_clk ? gclk_r : cin_d_r;
  assign rise = run_clk && cfg_load_clock_cur && !cfg_load_clock_prev;
  assign fall = run_clk && !cfg_load_clock_cur && cfg_load_clock_prev;

  // ----------------------------------------------------------------
  // data path: serial shift, byte capture, handshake, address
  // ----------------------------------------------------------------
  logic [2:0]  bitc_r, bitc_nxt;
  logic [7:0]  sh_r, sh_nxt, byte_r, byte_nxt;
  logic        bval_r, bval_nxt, busy_r, busy_nxt;
  logic [1:0]  dq_r, dq_nxt;
  logic        dout_r, dout_nxt, rck_r, rck_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic        sel, ws_eff, rs_eff, ws_d_r;
  assign sel    = !cs0 && cs1;
  assign ws_eff = sel && !ws_n;
  assign rs_eff = sel && !rs_n && ws_n;
  always_comb begin
    bitc_nxt = bitc_r;
    sh_nxt   = sh_r;
    byte_nxt = byte_r;
    bval_nxt = 1'b0;
    busy_nxt = busy_r;
    dq_nxt   = dq_r;
    dout_nxt = dout_r;
    rck_nxt  = 1'b0;
    addr_nxt = addr_r;
    if (st_r == CFG_LOAD) begin
      if (rise) begin
        dq_nxt = {dq_r[0], din};
        if (is_par && bitc_r == 3'h6) begin
          rck_nxt = 1'b1;
        end
        if (!is_par && !is_aperi && !is_speri) begin
          sh_nxt   = {sh_r[6:0], din};
          bitc_nxt = bitc_r + 3'h1;
          if (bitc_r == 3'h7) begin
            byte_nxt = {sh_r[6:0], din};
            bval_nxt = 1'b1;
          end
        end else if (is_par) begin
          bitc_nxt = bitc_r + 3'h1;
          if (bitc_r == 3'h7) begin
            byte_nxt = data_in;
            bval_nxt = 1'b1;
            addr_nxt = addr_r + 16'h0001;
          end
        end else if (is_speri && busy_r) begin
          bval_nxt = 1'b1;
          busy_nxt = 1'b0;
        end
      end
      if (fall) begin
        dout_nxt = dq_r[1];
      end
      if (is_aperi && ws_eff && !ws_d_r && !busy_r) begin
        byte_nxt = data_in;
        busy_nxt = 1'b1;
      end
      if (is_speri && ws_eff && !busy_r) begin
        byte_nxt = data_in;
        busy_nxt = 1'b1;
      end
      if (is_aperi && busy_r && i_byte_taken) begin
        busy_nxt = 1'b0;
        bval_nxt = 1'b1;
      end
    end else begin
      bitc_nxt = 3'h0;
      busy_nxt = 1'b0;
      addr_nxt = 16'h0000;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      div_r  <= 8'h00;
      gclk_r <= 1'b0;
      cin_d_r <= 1'b0;
      bitc_r <= 3'h0;
      sh_r   <= 8'h00;
      byte_r <= 8'h00;
      bval_r <= 1'b0;
      busy_r <= 1'b0;
      dq_r   <= 2'h0;
      dout_r <= 1'b1;
      rck_r  <= 1'b0;
      addr_r <= 16'h0000;
      ws_d_r <= 1'b0;
    end else begin
      div_r  <= div_nxt;
      gclk_r <= gclk_nxt;
      cin_d_r <= cfg_load_clock_in;
      bitc_r <= bitc_nxt;
      sh_r   <= sh_nxt;
      byte_r <= byte_nxt;
      bval_r <= bval_nxt;
      busy_r <= busy_nxt;
      dq_r   <= dq_nxt;
      dout_r <= dout_nxt;
      rck_r  <= rck_nxt;
      addr_r <= addr_nxt;
      ws_d_r <= ws_eff;
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  logic done_q, hold;
  assign done_q = (st_r == CFG_DONE);
  assign hold   = i_done_hold_en && !done_s2_r;
  always_comb begin
    o_mode_latched     = mode_r;
    o_mode_valid       = mvalid_r;
    o_cfg_load_clock   = '{o: gclk_r, oe_n: !(in_load && is_drv_clk &&
                          mvalid_r)};
    o_cfg_load_clock_pullup      = done_q;
    o_readback_clk     = done_q && cfg_load_clock_in;
    o_done             = '{o: 1'b0, oe_n: done_q};
    o_done_pullup      = done_q && i_done_pullup_en;
    o_gsr_release      = done_q && !hold;
    o_init             = '{o: 1'b0, oe_n: !(st_r == CFG_CLEAR ||
                          st_r == CFG_ERROR)};
    o_mem_clear        = (st_r == CFG_CLEAR);
    o_high_during_load = '{o: 1'b1, oe_n: done_q};
    o_low_during_load  = '{o: 1'b0, oe_n: done_q};
    o_ready_busy       = '{o: !busy_r, oe_n: !(in_load &&
                          (is_aperi || is_speri))};
    o_data_bit_seven   = '{o: !busy_r, oe_n: !(in_load && is_aperi &&
                          rs_eff)};
    o_addr_strobe      = '{o: rck_r, oe_n: !(in_load && is_par)};
    o_prom_addr_low    = addr_r;
    o_prom_addr_oe_n   = !(in_load && is_par);
    o_byte_data        = byte_r;
    o_byte_valid       = bval_r;
    o_serial_dout      = '{o: dout_r, oe_n: done_q};
    o_scan_enabled     = !done_q || i_scan_option;
    o_scan_to_logic    = done_q ? i_scan_pads : 3'h0;
    o_user_io_enable   = done_q && !hold;
    o_pullups_on       = !done_q;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  ldc_until_done_a: assert property (@(posedge i_sys_clk) disable iff
    (i_sys_rst) !done_q |-> !o_low_during_load.oe_n)
    else $error("low-during-load not driven");
  hdc_until_done_a: assert property (@(posedge i_sys_clk) disable iff
    (i_sys_rst) o_high_during_load.oe_n == done_q)
    else $error("high-during-load wrong");
  mode_hold_a: assert property (@(posedge i_sys_clk) disable iff
    (i_sys_rst) (mvalid_r && $past(mvalid_r)) |-> $stable(mode_r))
    else $error("mode changed after latch");
  clear_on_prog_a: assert property (@(posedge i_sys_clk) disable iff
    (i_sys_rst) !prog_n |=> o_mem_clear && o_init.oe_n == 1'b0)
    else $error("no clear on reprogram");
  clk_dir_a: assert property (@(posedge i_sys_clk) disable iff
    (i_sys_rst) (mvalid_r && in_load && (is_speri ||
    mode_r == MODE_SLAVE_SERIAL)) |-> o_cfg_load_clock.oe_n)
    else $error("clock driven in slave mode");
  err_init_a: assert property (@(posedge i_sys_clk) disable iff
    (i_sys_rst) (st_r == CFG_LOAD && i_data_error && prog_n) |=>
    !o_init.oe_n && !o_init.o)
    else $error("error not flagged");
  scan_off_a: assert property (@(posedge i_sys_clk) disable iff
    (i_sys_rst) (done_q && !i_scan_option) |-> !o_scan_enabled)
    else $error("scan still on");
  rdy_d7_a: assert property (@(posedge i_sys_clk) disable iff
    (i_sys_rst) !o_data_bit_seven.oe_n |->
    o_data_bit_seven.o == o_ready_busy.o)
    else $error("bit seven differs from ready");
  dout_fall_a: assert property (@(posedge i_sys_clk) disable iff
    (i_sys_rst) $changed(dout_r) && st_r == CFG_LOAD |-> $past(fall))
    else $error("serial out moved off falling edge");

endmodule

// ### shared/cfgpin_pkg.sv
// package for the configuration mode pin control block
package cfgpin_pkg;

  // ----------------------------------------------------------------
  // mode pin encodings, read as bit2:bit1:bit0
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_MASTER_PAR_LOW  = 3'h4;
  localparam logic [2:0] MODE_MASTER_PAR_HIGH = 3'h6;
  localparam logic [2:0] MODE_ASYNC_PERIPH    = 3'h5;
  localparam logic [2:0] MODE_SYNC_PERIPH     = 3'h3;
  localparam logic [2:0] MODE_MASTER_SERIAL   = 3'h0;
  localparam logic [2:0] MODE_SLAVE_SERIAL    = 3'h7;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_MHZ   = 100;
  localparam int unsigned CLR_CLK_NS    = 1000;
  localparam int unsigned CLR_TICK_CYC  = CLR_CLK_NS * SYS_CLK_MHZ / 1000;
  localparam int unsigned CFG_LOAD_CLOCK_HALF_CYC = 4;
  localparam int unsigned CLEAR_FRAMES  = 16;
  localparam int unsigned MODE_WAIT_TK  = 2;

  typedef enum logic [2:0] {
    CFG_CLEAR  = 3'b000,
    CFG_WAIT   = 3'b001,
    CFG_LOAD   = 3'b011,
    CFG_DONE   = 3'b010,
    CFG_ERROR  = 3'b110
  } cfgpin_state_t;

  // pin with output and active-low output enable
  typedef struct packed {
    logic o;
    logic oe_n;
  } cfgpin_pad_t;

endpackage

// ### testbench/cfgpin_ctrl_tb.sv
// self-checking bench for the configuration pin control block
module cfgpin_ctrl_tb;
  import cfgpin_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk, i_sys_rst, rep_n, hold_init, ext_done_low;
  logic [2:0] mode_sel, scan_pads;
  logic [7:0] data;
  logic cs_lo, cs_hi, ws_n, rs_n, derr, ldone, taken, hold_en;
  logic pull_en, scan_opt, run, lclk, sdin, init_n, done_pin;
  logic [2:0] mode_lat, scan_lg;
  logic mode_ok, cpu, rbclk, dpu, gsr, mclr, bval, scan_en, uio, pu;
  logic [15:0] paddr;
  logic paddr_oe_n;
  logic [7:0] bdata;
  cfgpin_pad_t cfg_load_clock_p, done_p, init_p, hdc_p, ldc_p, rdy_p, d7_p;
  cfgpin_pad_t as_p, sout_p;
  int fails, samples_checked, cyc;
  // plain copies of pad fields so the bounded wait can poll them
  logic init_oe, rdy_o, as_o;
  assign init_oe = init_p.oe_n;
  assign rdy_o   = rdy_p.o;
  assign as_o    = as_p.o;

  assign init_n = (init_p.oe_n | init_p.o) & ~hold_init;
  assign done_pin = (done_p.oe_n | done_p.o) & ~ext_done_low;
  assign run = mode_ok & ~uio & (mode_lat == MODE_SLAVE_SERIAL
             | mode_lat == MODE_SYNC_PERIPH);

  cfgpin_host_model host_u (.i_run(run), .i_byte(8'hA5),
    .o_load_clock(lclk), .o_serial_din(sdin));

  cfgpin_ctrl #(.CLR_FRAMES(2)) dut_u (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_reprogram_n(rep_n), .i_init_n(init_n), .i_mode_sel(mode_sel),
    .i_cfg_load_clock(lclk), .i_serial_din(sdin), .i_data(data),
    .i_chip_select_low(cs_lo), .i_chip_select_high(cs_hi),
    .i_write_strobe_n(ws_n), .i_read_strobe_n(rs_n),
    .i_done_pin(done_pin), .i_data_error(derr),
    .i_load_complete(ldone), .i_byte_taken(taken),
    .i_done_hold_en(hold_en), .i_done_pullup_en(pull_en),
    .i_scan_option(scan_opt), .i_scan_pads(scan_pads),
    .o_mode_latched(mode_lat), .o_mode_valid(mode_ok),
    .o_cfg_load_clock(cfg_load_clock_p), .o_cfg_load_clock_pullup(cpu),
    .o_readback_clk(rbclk), .o_done(done_p), .o_done_pullup(dpu),
    .o_gsr_release(gsr), .o_init(init_p), .o_mem_clear(mclr),
    .o_high_during_load(hdc_p), .o_low_during_load(ldc_p),
    .o_ready_busy(rdy_p), .o_data_bit_seven(d7_p),
    .o_addr_strobe(as_p), .o_prom_addr_low(paddr),
    .o_prom_addr_oe_n(paddr_oe_n), .o_byte_data(bdata),
    .o_byte_valid(bval), .o_serial_dout(sout_p),
    .o_scan_to_logic(scan_lg), .o_scan_enabled(scan_en),
    .o_user_io_enable(uio), .o_pullups_on(pu));

  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  // ----------------------------------------------------------------
  // shared checks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic clk_n(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask

  // bounded wait: pads flag as a mismatch when the limit runs out
  task automatic wait_for(ref logic s, input logic v, input int lim);
    int k;
    k = 0;
    while (s !== v && k < lim) begin
      clk_n(1);
      k++;
    end
    chk({7'h0, s}, {7'h0, v});
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_pins();
    chk({hdc_p.oe_n, hdc_p.o}, 8'h01);
    chk({ldc_p.oe_n, ldc_p.o}, 8'h00);
    chk({done_p.oe_n, done_p.o}, 8'h00);
    chk({7'h0, pu}, 8'h01);
    chk({7'h0, uio}, 8'h00);
  endtask

  task automatic t_config(input logic [2:0] m);
    mode_sel <= m;
    rep_n <= 1'b0;
    clk_n(10);
    chk({7'h0, mclr}, 8'h01);
    rep_n <= 1'b1;
    hold_init <= 1'b1;
    clk_n(260);
    chk({7'h0, mode_ok}, 8'h00);
    hold_init <= 1'b0;
    wait_for(init_oe, 1'b1, 20);
    wait_for(mode_ok, 1'b1, 400);
    chk({5'h0, mode_lat}, {5'h0, m});
    mode_sel <= ~m;
    clk_n(10);
    chk({5'h0, mode_lat}, {5'h0, m});
    chk({7'h0, cfg_load_clock_p.oe_n}, {7'h0, m == MODE_SLAVE_SERIAL
        || m == MODE_SYNC_PERIPH});
  endtask

  task automatic t_async_byte();
    cs_lo <= 1'b0;
    cs_hi <= 1'b1;
    data <= 8'h3C;
    ws_n <= 1'b0;
    rs_n <= 1'b0;
    clk_n(4);
    ws_n <= 1'b1;
    wait_for(rdy_o, 1'b0, 8);
    clk_n(4);
    chk({d7_p.oe_n, d7_p.o}, 8'h00);
    rs_n <= 1'b1;
    taken <= 1'b1;
    clk_n(1);
    taken <= 1'b0;
    wait_for(bval, 1'b1, 4);
    chk(bdata, 8'h3C);
    wait_for(rdy_o, 1'b1, 4);
    cs_lo <= 1'b1;
  endtask

  // strobe rises while the address still holds, the step follows it
  task automatic t_par_addr();
    wait_for(as_o, 1'b1, 200);
    chk(paddr[7:0], 8'h00);
    clk_n(12);
    chk(paddr[7:0], 8'h01);
  endtask

  task automatic t_finish();
    hold_en <= 1'b1;
    ext_done_low <= 1'b1;
    ldone <= 1'b1;
    clk_n(1);
    ldone <= 1'b0;
    clk_n(20);
    chk({7'h0, gsr}, 8'h00);
    ext_done_low <= 1'b0;
    wait_for(gsr, 1'b1, 50);
    chk({6'h0, done_p.oe_n, done_pin}, 8'h03);
    chk({7'h0, dpu}, 8'h01);
    chk({4'h0, hdc_p.oe_n, ldc_p.oe_n, rdy_p.oe_n, as_p.oe_n},
        8'h0F);
    chk({7'h0, uio}, 8'h01);
    chk({7'h0, cpu}, 8'h01);
    chk({7'h0, scan_en}, 8'h00);
    chk({5'h0, scan_lg}, {5'h0, scan_pads});
    hold_en <= 1'b0;
  endtask

  task automatic t_error();
    derr <= 1'b1;
    clk_n(1);
    derr <= 1'b0;
    clk_n(3);
    chk({init_p.oe_n, init_p.o}, 8'h00);
  endtask

  initial begin
    cyc = 0;
    forever begin
      @(posedge i_sys_clk);
      cyc++;
      if (cyc > 20000) begin
        fails++;
        summarize();
      end
    end
  end

  initial begin
    logic [2:0] modes [6];
    fails = 0;
    samples_checked = 0;
    modes = '{MODE_MASTER_PAR_LOW, MODE_MASTER_PAR_HIGH,
              MODE_MASTER_SERIAL, MODE_SLAVE_SERIAL,
              MODE_SYNC_PERIPH, MODE_ASYNC_PERIPH};
    {i_sys_rst, rep_n, hold_init, ext_done_low} = 4'h8;
    rep_n = 1'b1;
    {mode_sel, scan_pads, data} = {3'h0, 3'h5, 8'h00};
    {cs_lo, cs_hi, ws_n, rs_n, derr, ldone, taken} = 7'h58;
    {hold_en, pull_en, scan_opt} = 3'h2;
    clk_n(8);
    t_reset_pins();
    i_sys_rst <= 1'b0;
    foreach (modes[i]) begin
      t_config(modes[i]);
      if (modes[i] == MODE_MASTER_PAR_LOW) t_par_addr();
    end
    t_async_byte();
    t_finish();
    t_config(MODE_MASTER_SERIAL);
    t_error();
    summarize();
  end
endmodule

// ### testbench/cfgpin_host_model.sv
// far-side model: external load clock and serial bit source
module cfgpin_host_model (
  input  wire logic       i_run,
  input  wire logic [7:0] i_byte,
  output logic            o_load_clock,
  output logic            o_serial_din
);
  timeunit 1ns;
  timeprecision 1ps;
  int bit_idx;
  // ----------------------------------------------------------------
  // clock runs only within a load; fixed phase, edges 2 ns before a system clock rise
  // ----------------------------------------------------------------
  initial begin
    o_load_clock = 1'b0;
    o_serial_din = 1'b0;
    bit_idx = 7;
    #3;
    forever begin
      #40;
      if (i_run) begin
        o_load_clock = ~o_load_clock;
        if (!o_load_clock) begin
          o_serial_din = i_byte[bit_idx];
          bit_idx = (bit_idx == 0) ? 7 : bit_idx - 1;
        end
      end else begin
        o_load_clock = 1'b0;
        // idle data line toggles so no stale level looks valid
        o_serial_din = ~o_serial_din;
      end
    end
  end
endmodule
